// ===== rf_synth_pkg.sv
// Register map, field layout and constants of the synthesizer control bank
package rf_synth_pkg;

   // ****************************************************************
   // Register offsets
   // ****************************************************************
   localparam logic [7:0] ADDR_LOOP_POWER = 8'h0C;
   localparam logic [7:0] ADDR_TX_GATING  = 8'h0E;
   localparam logic [7:0] ADDR_LOCK_CTRL  = 8'h17;
   localparam logic [7:0] ADDR_AUTOCAL    = 8'h18;
   localparam logic [7:0] ADDR_MON_OSC    = 8'h1B;
   localparam logic [7:0] ADDR_OSC_POWER  = 8'h1C;
   localparam logic [7:0] ADDR_MOD_POWER  = 8'h1D;
   localparam logic [7:0] ADDR_ATTEN      = 8'h1E;
   localparam logic [7:0] ADDR_REVISION   = 8'h21;

   // ****************************************************************
   // Writable bits of each register, reset value and unmapped answer
   // ****************************************************************
   localparam logic [7:0] MASK_LOOP_POWER = 8'h04;
   localparam logic [7:0] MASK_TX_GATING  = 8'h3B;
   localparam logic [7:0] MASK_LOCK_CTRL  = 8'h1C;
   localparam logic [7:0] MASK_AUTOCAL    = 8'h01;
   localparam logic [7:0] MASK_MON_OSC    = 8'h0F;
   localparam logic [7:0] MASK_OSC_POWER  = 8'h20;
   localparam logic [7:0] MASK_MOD_POWER  = 8'h01;
   localparam logic [7:0] MASK_ATTEN      = 8'h3F;
   localparam logic [7:0] MASK_NONE       = 8'h00;
   localparam logic [7:0] REG_RESET       = 8'h00;

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int LOOP_PD_BIT     = 2;
   localparam int GATE_ATTEN_BIT  = 5;
   localparam int GATE_OSCBUF_BIT = 4;
   localparam int GATE_QUAD_BIT   = 3;
   localparam int GATE_DOUBL_BIT  = 1;
   localparam int GATE_RFPATH_BIT = 0;
   localparam int LOCK_EN_BIT     = 4;
   localparam int LOCK_COUNT_BIT  = 3;
   localparam int LOCK_FINE_BIT   = 2;
   localparam int AUTOCAL_OFF_BIT = 0;
   localparam int EXT_OSC_BIT     = 3;
   localparam int MON_PWR_BIT     = 2;
   localparam int MON_LEVEL_MSB   = 1;
   localparam int OSC_PD_BIT      = 5;
   localparam int MOD_PU_BIT      = 0;
   localparam int ATTEN_MSB       = 5;
   localparam int NUM_PATHS       = 5;

   // ****************************************************************
   // Lock detector, monitor level and attenuator constants
   // ****************************************************************
   localparam logic [11:0] LOCK_PULSES_COARSE = 12'hC00;
   localparam logic [11:0] LOCK_PULSES_FINE   = 12'h800;
   localparam logic [4:0]  LOCK_WINDOW_COARSE_NS = 5'h10;
   localparam logic [4:0]  LOCK_WINDOW_FINE_NS   = 5'h06;
   localparam logic [5:0]  MON_DBM_BASE   = 6'h28;
   localparam logic [5:0]  MON_DBM_STEP   = 6'h06;
   localparam logic [5:0]  ATTEN_LOW_MAX  = 6'h1F;
   localparam logic [1:0]  ATTEN_HIGH_TOP = 2'h3;
   localparam logic [5:0]  ATTEN_HIGH_OFS = 6'h10;
   localparam logic [5:0]  ATTEN_MAX_DB   = 6'h2F;

endpackage

// ===== tx_gate.sv
// Per-path enable gating by the synchronised transmit-off level
module tx_gate
(
   input  wire logic [rf_synth_pkg::NUM_PATHS-1:0] gate_bits,
   input  wire logic                               transmit_off,
   output logic      [rf_synth_pkg::NUM_PATHS-1:0] path_enable
);

   // A path is off only while its gate bit is set and the pin is high
   genvar i;
   generate
      for (i = 0; i < rf_synth_pkg::NUM_PATHS; i++)
      begin : g_path
         assign path_enable[i] = !(gate_bits[i] && transmit_off);
      end
   endgenerate

endmodule

// ===== atten_decode.sv
// Attenuation code to step count in dB, with gap detection
module atten_decode
(
   input  wire logic [5:0] code,
   output logic      [5:0] atten_db,
   output logic            code_valid
);

   // Low codes map straight; high codes drop the unused gap of 16
   always_comb
   begin
      if (code <= rf_synth_pkg::ATTEN_LOW_MAX)
      begin
         atten_db   = code;
         code_valid = 1'b1;
      end
      else if (code[5:4] == rf_synth_pkg::ATTEN_HIGH_TOP)
      begin
         atten_db   = code - rf_synth_pkg::ATTEN_HIGH_OFS;
         code_valid = 1'b1;
      end
      else
      begin
         atten_db   = rf_synth_pkg::ATTEN_LOW_MAX;            // Gap codes
         code_valid = 1'b0;
      end
   end

endmodule

// ===== rf_synth_control_registers.sv
// Control register bank of the modulator and synthesizer
//
// What this block does
// - Loop power bit 2 powers loop down.
// - Gating bit 5 disables attenuator on transmit-off.
// - Gating bit 4 disables oscillator buffer on transmit-off.
// - Gating bit 3 disables quadrature divider on transmit-off.
// - Gating bit 1 disables frequency doubler on transmit-off.
// - Gating bit 0 disables monitor path on transmit-off.
// - Lock control bit 4 enables lock detector.
// - Lock bit 3 picks 3072 or 2048 pulses.
// - Lock bit 2 picks 16 or 6 ns.
// - Autocal bit 0 disables oscillator calibration.
// - Select bit 3 picks external oscillator.
// - Select bit 2 powers up monitor output.
// - Two-bit level sets -24 to -6 dBm.
// - Oscillator power bit 5 powers oscillator down.
// - Modulator bit 0 powers modulator up.
// - Six-bit code maps 0-31 and 32-47 dB.
// - Read-only revision code at address 0x21.
module rf_synth_control_registers
#(
   parameter logic [7:0] REVISION_CODE = 8'h5A  // Arbitrary value
)
(
   input  wire logic        sys_clk,
   input  wire logic        srst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   input  wire logic        reg_write,
   input  wire logic        reg_read,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   input  wire logic        transmit_off_pin,
   input  wire logic        pfd_compare_pulse,
   input  wire logic        pfd_in_window,
   output logic             loop_power_down,
   output logic             attenuator_enable,
   output logic             osc_buffer_enable,
   output logic             quad_divider_enable,
   output logic             osc_doubler_enable,
   output logic             rf_monitor_enable,
   output logic             lock_detector_enable,
   output logic      [11:0] lock_pulse_target,
   output logic             lock_window_fine,
   output logic      [4:0]  lock_window_ns,
   output logic             lock_detected,
   output logic             autocal_enable,
   output logic             external_osc_select,
   output logic             osc_monitor_power_up,
   output logic      [1:0]  monitor_level,
   output logic      [5:0]  monitor_level_dbm,
   output logic             internal_osc_power_down,
   output logic             modulator_power_up,
   output logic      [5:0]  atten_db,
   output logic             atten_code_valid
);

   // ****************************************************************
   // State
   // ****************************************************************
   typedef struct packed {
      logic [7:0]  loop_power;
      logic [7:0]  tx_gating;
      logic [7:0]  lock_ctrl;
      logic [7:0]  autocal;
      logic [7:0]  mon_osc;
      logic [7:0]  osc_power;
      logic [7:0]  mod_power;
      logic [7:0]  atten;
      logic        tx_off_meta;
      logic        tx_off_sync;
      logic [4:0]  path_en;
      logic [11:0] lock_count;
      logic        locked;
      logic [7:0]  rdata;
      logic        rvalid;
   } state_t;

   state_t state_reg;
   state_t state_next;

   logic [4:0]  gate_bits;
   logic [4:0]  path_en_comb;
   logic [7:0]  wmask;
   logic [11:0] target;

   // ****************************************************************
   // Decoding functions
   // ****************************************************************

   // Writable bits at an address; zero for read-only and unmapped
   function automatic logic [7:0] write_mask(input logic [7:0] addr);
      case (addr)
         rf_synth_pkg::ADDR_LOOP_POWER: return rf_synth_pkg::MASK_LOOP_POWER;
         rf_synth_pkg::ADDR_TX_GATING:  return rf_synth_pkg::MASK_TX_GATING;
         rf_synth_pkg::ADDR_LOCK_CTRL:  return rf_synth_pkg::MASK_LOCK_CTRL;
         rf_synth_pkg::ADDR_AUTOCAL:    return rf_synth_pkg::MASK_AUTOCAL;
         rf_synth_pkg::ADDR_MON_OSC:    return rf_synth_pkg::MASK_MON_OSC;
         rf_synth_pkg::ADDR_OSC_POWER:  return rf_synth_pkg::MASK_OSC_POWER;
         rf_synth_pkg::ADDR_MOD_POWER:  return rf_synth_pkg::MASK_MOD_POWER;
         rf_synth_pkg::ADDR_ATTEN:      return rf_synth_pkg::MASK_ATTEN;
         default:                       return rf_synth_pkg::MASK_NONE;
      endcase
   endfunction

   // Read-back value; unmapped addresses answer zero
   function automatic logic [7:0] read_value(input logic [7:0] addr,
                                             input state_t     s);
      case (addr)
         rf_synth_pkg::ADDR_LOOP_POWER: return s.loop_power;
         rf_synth_pkg::ADDR_TX_GATING:  return s.tx_gating;
         rf_synth_pkg::ADDR_LOCK_CTRL:  return s.lock_ctrl;
         rf_synth_pkg::ADDR_AUTOCAL:    return s.autocal;
         rf_synth_pkg::ADDR_MON_OSC:    return s.mon_osc;
         rf_synth_pkg::ADDR_OSC_POWER:  return s.osc_power;
         rf_synth_pkg::ADDR_MOD_POWER:  return s.mod_power;
         rf_synth_pkg::ADDR_ATTEN:      return s.atten;
         rf_synth_pkg::ADDR_REVISION:   return REVISION_CODE;
         default:                       return rf_synth_pkg::REG_RESET;
      endcase
   endfunction

   // ****************************************************************
   // Transmit-off gating
   // ****************************************************************

   // Gate bits in path order: atten, buffer, divider, doubler, monitor
   assign gate_bits = {state_reg.tx_gating[rf_synth_pkg::GATE_ATTEN_BIT],
                       state_reg.tx_gating[rf_synth_pkg::GATE_OSCBUF_BIT],
                       state_reg.tx_gating[rf_synth_pkg::GATE_QUAD_BIT],
                       state_reg.tx_gating[rf_synth_pkg::GATE_DOUBL_BIT],
                       state_reg.tx_gating[rf_synth_pkg::GATE_RFPATH_BIT]};

   tx_gate u_tx_gate
   (
      .gate_bits    (gate_bits),
      .transmit_off (state_reg.tx_off_sync),
      .path_enable  (path_en_comb)
   );

   atten_decode u_atten_decode
   (
      .code       (state_reg.atten[rf_synth_pkg::ATTEN_MSB:0]),
      .atten_db   (atten_db),
      .code_valid (atten_code_valid)
   );

   // ****************************************************************
   // Next state
   // ****************************************************************

   // Pulse count needed to declare lock
   assign target = state_reg.lock_ctrl[rf_synth_pkg::LOCK_COUNT_BIT] ?
                   rf_synth_pkg::LOCK_PULSES_FINE :
                   rf_synth_pkg::LOCK_PULSES_COARSE;
   assign wmask  = write_mask(reg_addr);

   // Register writes, pin synchroniser, lock counting and read answer
   always_comb
   begin
      state_next             = state_reg;
      state_next.tx_off_meta = transmit_off_pin;
      state_next.tx_off_sync = state_reg.tx_off_meta;
      state_next.path_en     = path_en_comb;
      if (reg_write)
      begin
         // Reserved bits are masked off; revision has no write path
         case (reg_addr)
            rf_synth_pkg::ADDR_LOOP_POWER:
               state_next.loop_power = reg_wdata & wmask;
            rf_synth_pkg::ADDR_TX_GATING:
               state_next.tx_gating = reg_wdata & wmask;
            rf_synth_pkg::ADDR_LOCK_CTRL:
               state_next.lock_ctrl = reg_wdata & wmask;
            rf_synth_pkg::ADDR_AUTOCAL:
               state_next.autocal = reg_wdata & wmask;
            rf_synth_pkg::ADDR_MON_OSC:
               state_next.mon_osc = reg_wdata & wmask;
            rf_synth_pkg::ADDR_OSC_POWER:
               state_next.osc_power = reg_wdata & wmask;
            rf_synth_pkg::ADDR_MOD_POWER:
               state_next.mod_power = reg_wdata & wmask;
            rf_synth_pkg::ADDR_ATTEN:
               state_next.atten = reg_wdata & wmask;
            default:
               state_next.rvalid = state_reg.rvalid;
         endcase
      end
      // Lock detector counts in-window comparisons up to the target
      if (!state_reg.lock_ctrl[rf_synth_pkg::LOCK_EN_BIT])
      begin
         state_next.lock_count = '0;
         state_next.locked     = 1'b0;
      end
      else if (pfd_compare_pulse)
      begin
         if (!pfd_in_window)
         begin
            state_next.lock_count = '0;
            state_next.locked     = 1'b0;
         end
         else if (state_reg.lock_count + 12'h001 >= target)
         begin
            state_next.lock_count = target;
            state_next.locked     = 1'b1;
         end
         else
         begin
            state_next.lock_count = state_reg.lock_count + 12'h001;
         end
      end
      // Read answer one cycle after the strobe
      state_next.rvalid = reg_read;
      if (reg_read)
      begin
         state_next.rdata = read_value(reg_addr, state_reg);
      end
   end

   // ****************************************************************
   // State register
   // ****************************************************************

   // Synchronous reset to the documented defaults
   always_ff @(posedge sys_clk)
   begin
      if (srst)
      begin
         state_reg             <= '0;
         state_reg.path_en     <= '1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ****************************************************************
   // Outputs
   // ****************************************************************

   // Control fields from register bits; target, window and dBm decoded, autocal inverted
   assign reg_rdata   = state_reg.rdata;
   assign reg_rvalid  = state_reg.rvalid;
   assign loop_power_down =
      state_reg.loop_power[rf_synth_pkg::LOOP_PD_BIT];
   assign attenuator_enable   = state_reg.path_en[4];
   assign osc_buffer_enable   = state_reg.path_en[3];
   assign quad_divider_enable = state_reg.path_en[2];
   assign osc_doubler_enable  = state_reg.path_en[1];
   assign rf_monitor_enable   = state_reg.path_en[0];
   assign lock_detector_enable =
      state_reg.lock_ctrl[rf_synth_pkg::LOCK_EN_BIT];
   assign lock_pulse_target = target;
   assign lock_window_fine  =
      state_reg.lock_ctrl[rf_synth_pkg::LOCK_FINE_BIT];
   assign lock_window_ns = lock_window_fine ?
      rf_synth_pkg::LOCK_WINDOW_FINE_NS :
      rf_synth_pkg::LOCK_WINDOW_COARSE_NS;
   assign lock_detected = state_reg.locked;
   assign autocal_enable =
      !state_reg.autocal[rf_synth_pkg::AUTOCAL_OFF_BIT];
   assign external_osc_select =
      state_reg.mon_osc[rf_synth_pkg::EXT_OSC_BIT];
   assign osc_monitor_power_up =
      state_reg.mon_osc[rf_synth_pkg::MON_PWR_BIT];
   assign monitor_level =
      state_reg.mon_osc[rf_synth_pkg::MON_LEVEL_MSB:0];
   assign monitor_level_dbm = 6'(rf_synth_pkg::MON_DBM_BASE +
      6'(monitor_level) * rf_synth_pkg::MON_DBM_STEP);
   assign internal_osc_power_down =
      state_reg.osc_power[rf_synth_pkg::OSC_PD_BIT];
   assign modulator_power_up =
      state_reg.mod_power[rf_synth_pkg::MOD_PU_BIT];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   // All checks run on the bank clock and pause while reset is high
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);

   a_loop_pd_write: assert property (
      reg_write && reg_addr == rf_synth_pkg::ADDR_LOOP_POWER
      |=> loop_power_down == $past(reg_wdata[rf_synth_pkg::LOOP_PD_BIT]))
      else $error("loop power bit not taken");

   a_atten_gated: assert property (
      state_reg.tx_off_sync &&
      state_reg.tx_gating[rf_synth_pkg::GATE_ATTEN_BIT]
      |=> !attenuator_enable)
      else $error("attenuator not disabled on transmit-off");

   a_divider_free: assert property (
      !state_reg.tx_gating[rf_synth_pkg::GATE_QUAD_BIT]
      |=> quad_divider_enable)
      else $error("divider disabled without gate bit");

   a_pin_latency: assert property (
      transmit_off_pin ##1 transmit_off_pin ##1 transmit_off_pin &&
      state_reg.tx_gating[rf_synth_pkg::GATE_RFPATH_BIT]
      |=> !rf_monitor_enable)
      else $error("monitor path not gated after pin sync");

   a_lock_needs_en: assert property (
      $rose(lock_detected) |-> $past(lock_detector_enable))
      else $error("lock declared while detector disabled");

   a_lock_bound: assert property (
      $rose(lock_detected) |-> state_reg.lock_count == $past(target))
      else $error("lock declared before pulse target");

   a_autocal_off: assert property (
      reg_write && reg_addr == rf_synth_pkg::ADDR_AUTOCAL &&
      reg_wdata[rf_synth_pkg::AUTOCAL_OFF_BIT] |=> !autocal_enable)
      else $error("autocalibration not disabled");

   a_mod_power: assert property (
      reg_write && reg_addr == rf_synth_pkg::ADDR_MOD_POWER
      |=> modulator_power_up ==
      $past(reg_wdata[rf_synth_pkg::MOD_PU_BIT]) ##1
      $stable(modulator_power_up) || $past(reg_write))
      else $error("modulator power bit wrong");

   a_atten_range: assert property (
      atten_code_valid |-> atten_db <= rf_synth_pkg::ATTEN_MAX_DB &&
      (atten_db <= rf_synth_pkg::ATTEN_LOW_MAX) ==
      !state_reg.atten[rf_synth_pkg::ATTEN_MSB])
      else $error("attenuation out of range");

   a_rev_read: assert property (
      reg_read && reg_addr == rf_synth_pkg::ADDR_REVISION
      |=> reg_rvalid && reg_rdata == REVISION_CODE)
      else $error("revision code read wrong");

   a_reserved_zero: assert property (
      reg_read && reg_addr != rf_synth_pkg::ADDR_REVISION
      |=> (reg_rdata & ~$past(wmask)) == 8'h00)
      else $error("reserved bits read nonzero");

endmodule

// ===== rf_synth_host.sv
// Host controller model that drives the register port of the bank
module rf_synth_host
(
   input  wire logic       sys_clk,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_write,
   output logic            reg_read
);
   timeunit 1ns;
   timeprecision 1ns;

   // Idle port at time zero
   initial
   begin
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end

   // One access, strobe held over exactly the edge that takes it
   task automatic xfer(input logic [7:0] a, input logic [7:0] d,
                       input logic w);
      @(posedge sys_clk);
      #10;
      reg_addr = a;
      reg_wdata = d;
      reg_write = w;
      reg_read = !w;
      @(posedge sys_clk);
      #10;
      reg_write = 1'b0;
      reg_read = 1'b0;
      reg_wdata = ~d;   // Released data line does not keep its value
      reg_addr = ~a;
   endtask
endmodule

// ===== rf_synth_control_registers_bench.sv
// Self-checking bench of the synthesizer control register bank
module rf_synth_control_registers_bench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [7:0] REV = 8'hA7;  // Arbitrary value
   logic        sys_clk, srst, transmit_off_pin, pfd_compare_pulse;
   logic        pfd_in_window, reg_write, reg_read, reg_rvalid;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        loop_power_down, attenuator_enable, osc_buffer_enable;
   logic        quad_divider_enable, osc_doubler_enable, rf_monitor_enable;
   logic        lock_detector_enable, lock_window_fine, lock_detected;
   logic        autocal_enable, external_osc_select, osc_monitor_power_up;
   logic        internal_osc_power_down, modulator_power_up;
   logic        atten_code_valid;
   logic [11:0] lock_pulse_target;
   logic [4:0]  lock_window_ns;
   logic [4:0]  en, m;
   logic [1:0]  monitor_level;
   logic [5:0]  monitor_level_dbm, atten_db, c, e;
   logic [7:0]  g;
   logic [7:0]  q[$];
   logic [7:0]  ad[7] = '{8'h0C, 8'h0E, 8'h17, 8'h18, 8'h1B, 8'h1C, 8'h1E};
   logic [7:0]  mk[7] = '{8'h04, 8'h3B, 8'h1C, 8'h01, 8'h0F, 8'h20, 8'h3F};
   logic [5:0]  edge_codes[5] = '{6'h1F, 6'h20, 6'h2F, 6'h30, 6'h3F};
   int          err_total, n_compared, cycles;

   rf_synth_host host (.sys_clk, .reg_addr, .reg_wdata, .reg_write,
                       .reg_read);
   rf_synth_control_registers #(.REVISION_CODE(REV)) dut (.sys_clk, .srst,
      .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .reg_rvalid,
      .transmit_off_pin, .pfd_compare_pulse, .pfd_in_window,
      .loop_power_down, .attenuator_enable, .osc_buffer_enable,
      .quad_divider_enable, .osc_doubler_enable, .rf_monitor_enable,
      .lock_detector_enable, .lock_pulse_target, .lock_window_fine,
      .lock_window_ns, .lock_detected, .autocal_enable, .external_osc_select,
      .osc_monitor_power_up, .monitor_level, .monitor_level_dbm,
      .internal_osc_power_down, .modulator_power_up, .atten_db,
      .atten_code_valid);

   // Path enables in gate-bit order
   assign en = {attenuator_enable, osc_buffer_enable, quad_divider_enable,
                osc_doubler_enable, rf_monitor_enable};

   // ****************************************************************
   // Clock, helpers and verdict
   // ****************************************************************
   initial
   begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         err_total++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic step();
      @(posedge sys_clk);
      #10;
   endtask

   // Note the expected answer, then issue the read
   task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
      q.push_back(x);
      host.xfer(a, 8'h00, 1'b0);
   endtask

   task automatic pulses(input int n, input logic w);
      pfd_compare_pulse = 1'b1;
      pfd_in_window = w;
      repeat (n) @(posedge sys_clk);
      #10;
      pfd_compare_pulse = 1'b0;
      pfd_in_window = ~w;
   endtask

   // Count up to one short of the target, then the last pulse, then a miss
   task automatic lock_run(input logic [7:0] ctl, input int n,
                           input logic x);
      host.xfer(8'h17, ctl, 1'b1);
      step();
      check(lock_pulse_target, 16'(n));
      check(lock_window_ns, ctl[2] ? 16'h06 : 16'h10);
      pulses(n - 1, 1'b1);
      repeat (3) step();
      check(lock_detected, 16'h0);
      pulses(1, 1'b1);
      repeat (3) step();
      check(lock_detected, 16'(x));
      if (x)
      begin
         host.xfer(8'h1D, 8'h01, 1'b1);  // Modulator only once locked
         step();
         check(modulator_power_up, 16'h1);
      end
      pulses(1, 1'b0);
      repeat (3) step();
      check(lock_detected, 16'h0);
   endtask

   task automatic end_of_test();
      if (err_total == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // ****************************************************************
   // Read answer watcher and hang guard
   // ****************************************************************
   always @(negedge sys_clk)
   begin
      cycles++;
      if (reg_rvalid === 1'b1)
         check(reg_rdata, q.size() > 0 ? q.pop_front() : 8'hXX);
      if (cycles == 20000)
      begin
         err_total++;
         end_of_test();
      end
   end

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial
   begin
      srst = 1'b1;
      transmit_off_pin = 1'b0;
      pfd_compare_pulse = 1'b0;
      pfd_in_window = 1'b0;
      err_total = 0;
      n_compared = 0;
      cycles = 0;
      void'($urandom(53568));
      repeat (2) @(posedge sys_clk);
      #10;
      srst = 1'b0;
      step();
      check(loop_power_down, 16'h0);
      check(lock_detector_enable, 16'h0);
      check(external_osc_select, 16'h0);
      check(osc_monitor_power_up, 16'h0);
      check(internal_osc_power_down, 16'h0);
      check(modulator_power_up, 16'h0);
      check(autocal_enable, 16'h1);
      check(monitor_level_dbm, 16'h28);
      // Reset values, full writes and reserved bits dropped
      for (int i = 0; i < 7; i++)
      begin
         rdchk(ad[i], 8'h00);
         host.xfer(ad[i], 8'hFF, 1'b1);
         rdchk(ad[i], mk[i]);
      end
      host.xfer(8'h1D, 8'hFE, 1'b1);
      rdchk(8'h1D, 8'h00);
      host.xfer(8'h21, ~REV, 1'b1);
      rdchk(8'h21, REV);
      rdchk(8'h40, 8'h00);
      step();
      check(loop_power_down, 16'h1);
      check(lock_detector_enable, 16'h1);
      check(lock_window_fine, 16'h1);
      check(external_osc_select, 16'h1);
      check(osc_monitor_power_up, 16'h1);
      check(internal_osc_power_down, 16'h1);
      check(autocal_enable, 16'h0);
      // Every monitor level code
      for (int v = 0; v < 4; v++)
      begin
         host.xfer(8'h1B, 8'(v), 1'b1);
         step();
         check({monitor_level, monitor_level_dbm},
               {2'(v), 6'h28 + 6'(6 * v)});
      end
      // Attenuation codes, boundaries first, then random
      for (int i = 0; i < 24; i++)
      begin
         c = (i < 5) ? edge_codes[i] : 6'($urandom);
         e = (c < 6'h20) ? c : ((c >= 6'h30) ? c - 6'h10 : 6'h1F);
         host.xfer(8'h1E, {2'($urandom), c}, 1'b1);
         step();
         check({atten_code_valid, atten_db},
               {c < 6'h20 || c >= 6'h30, e});
      end
      // Random gating masks against the transmit-off pin
      for (int i = 0; i < 8; i++)
      begin
         g = 8'($urandom);
         m = ~{g[5], g[4], g[3], g[1], g[0]};
         host.xfer(8'h0E, g, 1'b1);
         rdchk(8'h0E, g & 8'h3B);
         transmit_off_pin = 1'b1;
         repeat (4) step();
         check(en, m);
         transmit_off_pin = 1'b0;
         repeat (4) step();
         check(en, 16'h1F);
      end
      // Lock detector disabled, short count, long count
      lock_run(8'h08, 2048, 1'b0);
      lock_run(8'h18, 2048, 1'b1);
      lock_run(8'h14, 3072, 1'b1);
      // Mid-run reset returns written fields to their defaults
      srst = 1'b1;
      repeat (2) step();
      srst = 1'b0;
      step();
      check(modulator_power_up, 16'h0);
      check(autocal_enable, 16'h1);
      rdchk(8'h17, 8'h00);
      repeat (4) step();
      check(16'(q.size()), 16'h0);
      end_of_test();
   end
endmodule
